// [uarx_rx.sv]
/*
 Receive recovery front end with an AHB-Lite register slave.
 Assumes the serial input is synchronous-sampled through two flops and
 that the remote transmitter keeps its rate in the tolerance window.
*/
// The AHB-Lite interface to the registers and the address map were left to the implementer.
module uarx_rx (
	input wire logic hclk, // System clock, 20 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write strobe
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready in
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Always ready
	output logic hresp, // Always OKAY
	input wire logic serial_receive_input, // Serial line
	output logic irq // Level interrupt
);
	import uarx_pkg::*;

	// Bus address phase capture
	logic wr_reg, rd_reg;
	logic [7:0] addr_reg;
	wire take = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			addr_reg <= 8'h00;
		end else begin
			wr_reg <= take && hwrite;
			rd_reg <= take && !hwrite;
			addr_reg <= haddr[7:0];
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Register write decodes and data read decode
	wire wr_ctrl = wr_reg && (addr_reg == UARX_CTRL_OFF);
	wire wr_div = wr_reg && (addr_reg == UARX_DIV_OFF);
	wire wr_ien = wr_reg && (addr_reg == UARX_IEN_OFF);
	wire wr_iclr = wr_reg && (addr_reg == UARX_ICLR_OFF);
	wire rd_data = rd_reg && (addr_reg == UARX_DATA_OFF);

	// Software registers
	logic [31:0] ctrl_reg;
	logic [15:0] baud_divisor;
	logic [1:0] ien_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= UARX_CTRL_RST;
			baud_divisor <= UARX_DIV_RST;
			ien_reg <= 2'h0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= hwdata;
			if (wr_div)
				baud_divisor <= hwdata[15:0];
			if (wr_ien)
				ien_reg <= hwdata[1:0];
		end
	end
	wire receiver_on = ctrl_reg[UARX_C_ON];
	wire double_speed_select = ctrl_reg[UARX_C_DBL];
	wire parity_check_on = ctrl_reg[UARX_C_PAR];
	wire parity_odd_select = ctrl_reg[UARX_C_ODD];
	// Length clamped so a bad setting still yields a 5..9 bit char
	wire [3:0] len_raw = ctrl_reg[UARX_C_LEN +: 4];
	wire [3:0] char_len = (len_raw < UARX_LEN_MIN) ? UARX_LEN_MIN :
		(len_raw > UARX_LEN_MAX) ? UARX_LEN_MAX : len_raw;

	logic sync1_reg, sync2_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= serial_receive_input;
			sync2_reg <= sync1_reg;
		end
	end

	logic [15:0] div_reg;
	wire tick = receiver_on && (div_reg == 16'h0000);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_reg <= 16'h0000;
		else if (!receiver_on || tick)
			div_reg <= baud_divisor;
		else
			div_reg <= div_reg - 16'h0001;
	end

	wire [4:0] spb = double_speed_select ? UARX_SPB_DBL : UARX_SPB_NORM;
	wire [4:0] vfirst = double_speed_select ? UARX_VOTE_DBL : UARX_VOTE_NORM;
	wire [4:0] vlast = vfirst + 5'h02;

	// Recovery state
	uarx_state_t state_reg;
	logic [4:0] samp_reg; // Sample number inside bit
	logic [3:0] bit_reg; // Bit index in frame
	logic [1:0] vote_reg; // High samples counted
	logic prev_reg; // Line on previous tick
	logic [9:0] shift_reg; // Data then parity
	wire s = sync2_reg;
	wire [1:0] votes = vote_reg + {1'b0, s};
	wire maj = votes[1];
	// Frame: char bits, optional parity, stop
	wire [3:0] par_len = char_len + {3'h0, parity_check_on};
	wire stop_bit = (bit_reg == par_len);
	wire at_vote_end = tick && (samp_reg == vlast);
	wire in_vote = (samp_reg >= vfirst) && (samp_reg <= vlast);

	// Frame result
	logic [8:0] data_reg;
	logic ferr_reg, perr_reg, pend_reg, ovr_reg;
	wire [9:0] frame_bits = {maj, shift_reg[9:1]};
	// Data right-justified by length
	// Stop bit is not shifted in yet, so the stored bits are aligned
	wire [9:0] aligned = shift_reg >> (4'd10 - par_len);
	wire [8:0] char_mask = 9'h1ff >> (4'd9 - char_len);
	wire par_rx = aligned[char_len];
	wire par_calc = ^(aligned[8:0] & char_mask) ^ parity_odd_select;
	wire frame_done = (state_reg == UARX_BITS) && at_vote_end && stop_bit;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= UARX_IDLE;
			samp_reg <= 5'h00;
			bit_reg <= 4'h0;
			vote_reg <= 2'h0;
			prev_reg <= 1'b1;
			shift_reg <= 10'h000;
		end else if (!receiver_on) begin
			state_reg <= UARX_IDLE;
			prev_reg <= 1'b1;
		end else if (tick) begin
			prev_reg <= s;
			// Wrap at or past the end, so a mode switch cannot overrun
			samp_reg <= (samp_reg >= spb) ? 5'h01 : samp_reg + 5'h01;
			vote_reg <= in_vote ? votes : 2'h0;
			if (samp_reg >= spb)
				vote_reg <= 2'h0;
			case (state_reg)
				UARX_IDLE: begin
					// Falling edge: first low is sample one
					if (prev_reg && !s) begin
						state_reg <= UARX_START;
						samp_reg <= 5'h02;
						vote_reg <= 2'h0;
					end
				end
				UARX_START: begin
					if (samp_reg == vlast) begin
						if (maj)
							state_reg <= UARX_IDLE;
						else begin
							state_reg <= UARX_BITS;
							bit_reg <= 4'h0;
						end
					end
				end
				default: begin
					if (samp_reg == vlast) begin
						shift_reg <= frame_bits;
						bit_reg <= bit_reg + 4'h1;
						if (stop_bit) begin
							state_reg <= UARX_IDLE;
							bit_reg <= 4'h0;
							prev_reg <= double_speed_select ? 1'b0 : 1'b1;
						end
					end
				end
			endcase
		end
	end

	// Frame store; a read empties it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_reg <= 9'h000;
			ferr_reg <= 1'b0;
			perr_reg <= 1'b0;
			pend_reg <= 1'b0;
			ovr_reg <= 1'b0;
		end else if (!receiver_on) begin
			pend_reg <= 1'b0;
			ferr_reg <= 1'b0;
			perr_reg <= 1'b0;
		end else if (frame_done) begin
			data_reg <= aligned[8:0] & char_mask;
			// Zero stop bit is frame error
			ferr_reg <= !maj;
			perr_reg <= parity_check_on && (par_rx != par_calc);
			pend_reg <= 1'b1;
			ovr_reg <= pend_reg && !rd_data;
		end else if (rd_data) begin
			pend_reg <= 1'b0;
		end
	end
	wire stop_bit_error_flag = ferr_reg;
	wire parity_fault_flag = perr_reg;
	wire receive_pending_flag = pend_reg;

	// Sticky events: bit0 frame received, bit1 frame error
	logic [1:0] ista_reg;
	wire [1:0] iev = {frame_done && !maj, frame_done};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ista_reg <= 2'h0;
		else
			// Set wins over a same-cycle clear
			ista_reg <= (ista_reg & ~(wr_iclr ? hwdata[1:0] : 2'h0)) | iev;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(ista_reg & ien_reg);
	end

	// Read mux, registered
	wire [31:0] stat_word = {24'h0, ista_reg, 1'b0, ovr_reg,
		parity_fault_flag, stop_bit_error_flag, receive_pending_flag,
		state_reg == UARX_IDLE};
	wire [31:0] receive_data_port = {23'h0, data_reg};
	wire [31:0] rmux = (haddr[7:0] == UARX_CTRL_OFF) ? ctrl_reg :
		(haddr[7:0] == UARX_DIV_OFF) ? {16'h0, baud_divisor} :
		(haddr[7:0] == UARX_DATA_OFF) ? receive_data_port :
		(haddr[7:0] == UARX_STAT_OFF) ? stat_word :
		(haddr[7:0] == UARX_IEN_OFF) ? {30'h0, ien_reg} : 32'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (take && !hwrite)
			hrdata <= rmux;
	end

	// Checks
	property p_disable_idle;
		@(posedge hclk) disable iff (!hresetn)
		!receiver_on |=> (state_reg == UARX_IDLE) && !pend_reg;
	endproperty
	a_disable_idle: assert property (p_disable_idle) else $error("receiver not idle when off");
	property p_done_pend;
		@(posedge hclk) disable iff (!hresetn)
		frame_done |=> pend_reg && (ferr_reg == !$past(maj));
	endproperty
	a_done_pend: assert property (p_done_pend) else $error("frame store wrong");
	property p_reject;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == UARX_START) && at_vote_end && maj && receiver_on
			|=> state_reg == UARX_IDLE;
	endproperty
	a_reject: assert property (p_reject) else $error("noise start accepted");
	property p_accept;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == UARX_START) && at_vote_end && !maj && receiver_on
			|=> state_reg == UARX_BITS && bit_reg == 4'h0;
	endproperty
	a_accept: assert property (p_accept) else $error("valid start lost");
	property p_samp_range;
		@(posedge hclk) disable iff (!hresetn)
		samp_reg <= UARX_SPB_NORM;
	endproperty
	a_samp_range: assert property (p_samp_range) else $error("sample count out of range");
	property p_par_off;
		@(posedge hclk) disable iff (!hresetn)
		frame_done && !parity_check_on |=> !perr_reg;
	endproperty
	a_par_off: assert property (p_par_off) else $error("parity flag without check");
	// Enabled frame error: event bit first, then the output
	sequence s_ferr_enabled;
		frame_done && !maj && ien_reg[1];
	endsequence
	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		s_ferr_enabled |=> ##1 irq;
	endproperty
	a_irq: assert property (p_irq) else $error("frame error irq missing");
	property p_bits_bound;
		@(posedge hclk) disable iff (!hresetn)
		bit_reg <= 4'ha;
	endproperty
	a_bits_bound: assert property (p_bits_bound) else $error("bit index overrun");
	// Idle falling edge numbers the next sample as two
	property p_start_edge;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == UARX_IDLE) && tick && prev_reg && !s
			|=> state_reg == UARX_START && samp_reg == 5'h02;
	endproperty
	a_start_edge: assert property (p_start_edge) else $error("start edge not taken");
endmodule

// [uarx_pkg.sv]
/*
 Package for the asynchronous receive recovery block: register offsets,
 field positions, reset values and the recovery state encoding.
 Assumes a single system clock and an AHB-Lite register bus.
*/
// How it works
// - Sample sixteen per bit, eight at double speed
// - Idle falling edge starts detection, sample one
// - Start vote: samples 8-10, or 4-6
// - Majority high start is noise; rearm
// - Valid start realigns bit phase every frame
// - Per-bit sample counter: sixteen or eight states
// - Bit value is center three-sample majority
// - Recover through first stop; ignore extra stops
// - Zero stop bit sets frame error flag
// - Next start accepted right after stop vote; at double speed only once a high sample follows it
// - Character plus parity from five to ten bits
// - Each side keeps half the total error
// - Optional odd/even parity check stored with frame
// - Receiver off aborts frame and empties buffer
package uarx_pkg;
	// Register byte offsets
	localparam logic [7:0] UARX_CTRL_OFF = 8'h00;
	localparam logic [7:0] UARX_DIV_OFF = 8'h04;
	localparam logic [7:0] UARX_DATA_OFF = 8'h08;
	localparam logic [7:0] UARX_STAT_OFF = 8'h0c;
	localparam logic [7:0] UARX_IEN_OFF = 8'h10;
	localparam logic [7:0] UARX_ICLR_OFF = 8'h14;
	// Control field positions
	localparam int UARX_C_ON = 0;
	localparam int UARX_C_DBL = 1;
	localparam int UARX_C_PAR = 2;
	localparam int UARX_C_ODD = 3;
	localparam int UARX_C_LEN = 4; // 4 bits: char bits 5..9
	// Reset values
	localparam logic [31:0] UARX_CTRL_RST = 32'h0000_0080; // 8 data bits
	localparam logic [15:0] UARX_DIV_RST = 16'h0000;
	// Sampling constants
	localparam logic [4:0] UARX_SPB_NORM = 5'h10;
	localparam logic [4:0] UARX_SPB_DBL = 5'h08;
	localparam logic [4:0] UARX_VOTE_NORM = 5'h08; // first vote sample
	localparam logic [4:0] UARX_VOTE_DBL = 5'h04;
	localparam logic [3:0] UARX_LEN_MIN = 4'h5;
	localparam logic [3:0] UARX_LEN_MAX = 4'h9;
	// Recovery states
	typedef enum logic [2:0] {
		UARX_IDLE = 3'b001,
		UARX_START = 3'b010,
		UARX_BITS = 3'b100
	} uarx_state_t;
	// One received frame as stored
	typedef struct packed {
		logic perr;
		logic ferr;
		logic [8:0] data;
	} uarx_frame_t;
endpackage

// [uarx_line_model.sv]
/*
 Behavioural remote transmitter that drives the serial line.
 Assumes the bench sets bit_clks to the receiver's bit period in clocks.
*/
module uarx_line_model (
	input wire logic hclk, // System clock
	output logic serial_line // Serial line, idle high
);
	timeunit 1ns;
	timeprecision 1ns;
	int bit_clks = 32; // Clocks per bit
	initial serial_line = 1'b1;
	// Hold one level for n clocks
	task automatic hold(input logic v, input int n);
		@(posedge hclk);
		serial_line <= v;
		repeat (n - 1) @(posedge hclk);
	endtask
	// Rate set by bit_clks
	// Start, data LSB first, optional parity, one stop of chosen length
	task automatic send(input logic [8:0] d, input int nb, input logic par, odd, flip, stp,
		input int stop_clks);
		logic p;
		p = odd;
		hold(1'b0, bit_clks);
		for (int i = 0; i < nb; i++) begin
			hold(d[i], bit_clks);
			p = p ^ d[i];
		end
		if (par) begin
			hold(p ^ flip, bit_clks);
		end
		hold(stp, stop_clks);
		// Back to idle; never leaves a stale low behind
		hold(1'b1, 1);
	endtask
	// Short low spike, then a full idle bit
	task automatic glitch(input int n);
		hold(1'b0, n);
		hold(1'b1, bit_clks);
	endtask
endmodule

// [test_uarx_rx.sv]
/*
 Self-checking bench for the receive recovery block.
 Assumes zero-wait AHB-Lite slave and divisor 1 (two clocks per tick).
*/
module test_uarx_rx;
	timeunit 1ns;
	timeprecision 1ns;
	import uarx_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rx_line;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	int error_cnt = 0;
	int checked = 0;
	uarx_rx dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .serial_receive_input(rx_line), .irq(irq));
	uarx_line_model line (.hclk(hclk), .serial_line(rx_line));
	// 20 MHz clock
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Single transfer; each phase held until hready is seen high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, exp);
		xfer(1'b0, a, 32'h0);
		check(what, rd & m, exp);
	endtask
	// Poll until a frame is pending; bounded so a lost frame cannot hang
	task automatic wait_rx;
		int n;
		n = 0;
		do begin
			xfer(1'b0, UARX_STAT_OFF, 32'h0);
			n++;
		end while (rd[1] !== 1'b1 && n < 1000);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("ctrl reset", UARX_CTRL_OFF, 32'hff, UARX_CTRL_RST);
		rchk("unmapped", 8'h20, 32'hffff_ffff, 32'h0);
		xfer(1'b1, UARX_DIV_OFF, 32'h1);
		rchk("divisor", UARX_DIV_OFF, 32'hffff, 32'h1);
		xfer(1'b1, UARX_IEN_OFF, 32'h1);
		xfer(1'b1, UARX_CTRL_OFF, 32'h81);
		line.send(9'h0a5, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
		wait_rx;
		rchk("stat good", UARX_STAT_OFF, 32'hce, 32'h42);
		check("irq rx", {31'h0, irq}, 32'h1);
		rchk("data a5", UARX_DATA_OFF, 32'hff, 32'ha5);
		rchk("pending clr", UARX_STAT_OFF, 32'h2, 32'h0);
		$display("test basic done");
		xfer(1'b1, UARX_IEN_OFF, 32'h3);
		line.send(9'h03c, 8, 1'b0, 1'b0, 1'b0, 1'b0, 32);
		wait_rx;
		rchk("stat ferr", UARX_STAT_OFF, 32'h84, 32'h84);
		check("irq ferr", {31'h0, irq}, 32'h1);
		rchk("data 3c", UARX_DATA_OFF, 32'hff, 32'h3c);
		xfer(1'b1, UARX_ICLR_OFF, 32'h3);
		repeat (2) @(posedge hclk);
		check("irq clr", {31'h0, irq}, 32'h0);
		rchk("events clr", UARX_STAT_OFF, 32'hc0, 32'h0);
		xfer(1'b1, UARX_IEN_OFF, 32'h2);
		line.send(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
		wait_rx;
		check("irq masked", {31'h0, irq}, 32'h0);
		rchk("data 55", UARX_DATA_OFF, 32'hff, 32'h55);
		$display("test errors and interrupt done");
		xfer(1'b1, UARX_CTRL_OFF, 32'h51);
		line.glitch(8);
		rchk("noise", UARX_STAT_OFF, 32'h3, 32'h1);
		line.send(9'h015, 5, 1'b0, 1'b0, 1'b0, 1'b1, 32);
		wait_rx;
		rchk("five bits", UARX_DATA_OFF, 32'h1f, 32'h15);
		xfer(1'b1, UARX_CTRL_OFF, 32'h81);
		fork
			begin
				line.send(9'h0c3, 8, 1'b0, 1'b0, 1'b0, 1'b1, 22);
				line.send(9'h03c, 8, 1'b0, 1'b0, 1'b0, 1'b1, 32);
			end
			begin
				wait_rx;
				rchk("first", UARX_DATA_OFF, 32'hff, 32'hc3);
				wait_rx;
				rchk("second", UARX_DATA_OFF, 32'hff, 32'h3c);
			end
		join
		line.bit_clks = 31;
		line.send(9'h05a, 8, 1'b0, 1'b0, 1'b0, 1'b1, 31);
		wait_rx;
		rchk("fast tx", UARX_DATA_OFF, 32'hff, 32'h5a);
		$display("test noise and spacing done");
		xfer(1'b1, UARX_CTRL_OFF, 32'h9f);
		line.bit_clks = 16;
		line.send(9'h1a5, 9, 1'b1, 1'b1, 1'b0, 1'b1, 16);
		wait_rx;
		rchk("par ok", UARX_STAT_OFF, 32'h8, 32'h0);
		rchk("dbl data", UARX_DATA_OFF, 32'h1ff, 32'h1a5);
		line.send(9'h0f0, 9, 1'b1, 1'b1, 1'b1, 1'b1, 16);
		wait_rx;
		rchk("par bad", UARX_STAT_OFF, 32'h8, 32'h8);
		rchk("dbl data2", UARX_DATA_OFF, 32'h1ff, 32'h0f0);
		fork
			line.send(9'h1ff, 9, 1'b1, 1'b0, 1'b0, 1'b1, 16);
			begin
				repeat (48) @(posedge hclk);
				xfer(1'b1, UARX_CTRL_OFF, 32'h9e);
			end
		join
		rchk("abort", UARX_STAT_OFF, 32'he, 32'h0);
		$display("test double speed and abort done");
		summarize;
	end
	// Hang guard, well beyond the expected run
	initial begin
		repeat (60000) @(posedge hclk);
		error_cnt++;
		summarize;
	end
endmodule
